// [rtl/tiopg_pkg.sv]
package tiopg_pkg;

   // output source selection
   typedef enum logic [1:0] {
      tiopg_src_on_acq  = 2'h0,
      tiopg_src_armed   = 2'h1,
      tiopg_src_manual  = 2'h3
   } tiopg_src_t;

   localparam int          tiopg_width_w     = 24;
   localparam logic [23:0] tiopg_width_reset = 24'h00_4E20; // 100 us
   localparam int          tiopg_opcond_w    = 16;
   localparam int          tiopg_ready_bit   = 5;
   localparam logic        tiopg_dir_input   = 1'b0;
   localparam logic        tiopg_dir_output  = 1'b1;
   localparam logic        tiopg_level_reset = 1'b0;

   // per-connector configuration
   typedef struct packed {
      logic                      dir_out;
      tiopg_src_t                src;
      logic                      idle_level;
      logic [tiopg_width_w-1:0]  width;
   } tiopg_cfg_t;

endpackage : tiopg_pkg

// [rtl/tiopg_sync.sv]
`timescale 1ns/1ps
// three-stage synchroniser; output changes once stages two and three agree
module tiopg_sync (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic din,
   output logic      dout
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1   <= 1'b0;
         s2   <= 1'b0;
         s3   <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            dout <= s3;
         end
      end
   end
endmodule : tiopg_sync

// [rtl/tiopg_pulse.sv]
`timescale 1ns/1ps
// width counter for one connector's trigger pulse
module tiopg_pulse #(
   parameter int W = 24
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         start,
   input  wire logic [W-1:0] width,
   output logic              active
);
   logic [W-1:0] count;
   // a zero width still gives one cycle, never a lost pulse
   wire [W-1:0]  span = (width == '0) ? W'(1) : width;
   wire          load = start && !active;   // R13
   wire          last = (count == W'(1));

   if (W < 2) begin : g_bad_w
      $error("tiopg_pulse: W too small");
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         count  <= '0;
         active <= 1'b0;
      end else if (load) begin
         // the start cycle already shows on the pin, so the counter
         // only covers the remaining span - 1 cycles
         count  <= span - W'(1); // R11
         active <= (span != W'(1)); // R11
      end else if (active) begin
         count  <= count - W'(1);
         if (last) begin
            active <= 1'b0; // R13
         end
      end
   end
endmodule : tiopg_pulse

// [rtl/tiopg_top.sv]
`timescale 1ns/1ps
// Behaviour
// R1 - connector one is input only and is never driven.
// R2 - connectors two and three each have their own direction setting.
// R3 - a connector set to input is not driven and feeds the external trigger.
// R4 - a connector set to output is driven per its source selection.
// R5 - the source selection resets to the on-acquisition choice.
// R6 - the armed source drives high while the device is ready for trigger.
// R7 - ready shows in operation condition bit 5 and as a low aux output.
// R8 - the manual source pulses only on fire and else holds the idle level.
// R9 - the idle level bit picks constant high (1) or constant low (0).
// R10 - the manual pulse is always opposite to the idle level.
// R11 - the pulse width equals the programmed pulse length; a programmed length of zero still gives a one-cycle pulse.
// R12 - fire starts the pulse at once, without waiting for a measurement.
// R13 - width counts clock cycles, ends at idle, fire while busy is ignored.
// R14 - on-acquisition pulses use the same width counter, one full length.
module tiopg_top #(
   parameter int W = tiopg_pkg::tiopg_width_w
) (
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                trig1_in,
   input  wire logic [1:0]          trigx_in,
   output logic [1:0]               trigx_out,
   output logic [1:0]               trigx_oe,
   input  wire logic [1:0]          cfg_dir_out,
   input  wire logic [3:0]          cfg_src,
   input  wire logic [1:0]          cfg_idle_level,
   input  wire logic [2*W-1:0]      cfg_width,
   input  wire logic                cfg_write,
   input  wire logic [1:0]          fire,
   input  wire logic                acq_trigger,
   input  wire logic                ready_for_trigger,
   output logic                     ext_trig1,
   output logic [1:0]               ext_trigx,
   output logic [tiopg_pkg::tiopg_opcond_w-1:0] operation_condition_register,
   output logic                     aux_ready_n
);

   // the stored width field is fixed by the package struct
   if (W != tiopg_pkg::tiopg_width_w) begin : g_bad_w
      $error("tiopg_top: W must match the package width");
   end

   // connector one: synchronised and passed on only, no driver exists
   tiopg_sync u_sync1 (            // R1
      .clk  (clk),
      .rstn (rstn),
      .din  (trig1_in),
      .dout (ext_trig1)
   );

   tiopg_pkg::tiopg_cfg_t cfg [2];
   logic                  ready_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ready_q                      <= 1'b0;
         operation_condition_register <= '0;
         aux_ready_n                  <= 1'b1;
      end else begin
         ready_q <= ready_for_trigger;
         operation_condition_register <= '0;
         operation_condition_register[tiopg_pkg::tiopg_ready_bit]
            <= ready_for_trigger; // R7
         aux_ready_n <= !ready_for_trigger; // R7
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_conn
         logic                   sync_in;
         logic                   active;
         logic                   next_level;
         tiopg_pkg::tiopg_src_t  src_w;
         wire  [1:0]             src_raw = cfg_src[2*g +: 2];
         wire  [W-1:0]           width_w = cfg_width[W*g +: W];
         // an undefined source code falls back to on-acquisition
         assign src_w = (src_raw == 2'h2) ? tiopg_pkg::tiopg_src_on_acq
                                          : tiopg_pkg::tiopg_src_t'(src_raw);

         tiopg_sync u_sync (
            .clk  (clk),
            .rstn (rstn),
            .din  (trigx_in[g]),
            .dout (sync_in)
         );

         always_ff @(posedge clk) begin
            if (!rstn) begin
               cfg[g].dir_out    <= tiopg_pkg::tiopg_dir_input;
               cfg[g].src        <= tiopg_pkg::tiopg_src_on_acq; // R5
               cfg[g].idle_level <= tiopg_pkg::tiopg_level_reset;
               cfg[g].width      <= tiopg_pkg::tiopg_width_reset;
            end else if (cfg_write) begin
               cfg[g].dir_out    <= cfg_dir_out[g]; // R2
               cfg[g].src        <= src_w;
               cfg[g].idle_level <= cfg_idle_level[g]; // R9
               cfg[g].width      <= width_w;
            end
         end

         wire is_manual = cfg[g].src == tiopg_pkg::tiopg_src_manual;
         wire is_acq    = cfg[g].src == tiopg_pkg::tiopg_src_on_acq;
         wire start     = cfg[g].dir_out &&
                          ((is_manual && fire[g]) || // R8 R12
                           (is_acq && acq_trigger)); // R14

         tiopg_pulse #(.W(W)) u_pulse (
            .clk    (clk),
            .rstn   (rstn),
            .start  (start),
            .width  (cfg[g].width),
            .active (active)
         );

         // the counter lags start by one cycle, so start itself opens the
         // pulse to keep fire immediate
         wire pulse_on = active || start; // R12
         always_comb begin
            unique case (cfg[g].src)
               tiopg_pkg::tiopg_src_armed:  next_level = ready_q; // R6
               tiopg_pkg::tiopg_src_manual:
                  next_level = cfg[g].idle_level ^ pulse_on; // R8 R10
               default:                     next_level = pulse_on; // R14
            endcase
         end

         always_ff @(posedge clk) begin
            if (!rstn) begin
               trigx_out[g] <= 1'b0;
               trigx_oe[g]  <= 1'b0;
               ext_trigx[g] <= 1'b0;
            end else begin
               trigx_oe[g]  <= cfg[g].dir_out; // R3 R4
               trigx_out[g] <= cfg[g].dir_out ? next_level : 1'b0; // R4
               ext_trigx[g] <= cfg[g].dir_out ? 1'b0 : sync_in; // R3
            end
         end
      end
   endgenerate

endmodule : tiopg_top

// [bench/tiopg_ext.sv]
`timescale 1ns/1ps
// attached equipment: drives a connector only while the device releases it
module tiopg_ext (
   input  wire logic [1:0] oe,
   input  wire logic [1:0] out,
   input  wire logic [1:0] lvl,
   output logic [1:0]      pin
);
   assign pin = (oe & out) | (~oe & lvl);
endmodule : tiopg_ext

// [bench/tiopg_chk.sv]
`timescale 1ns/1ps
module tiopg_chk (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        trig1_in,
   input wire logic [1:0]  trigx_in,
   input wire logic [1:0]  trigx_out,
   input wire logic [1:0]  trigx_oe,
   input wire logic [1:0]  cfg_dir_out,
   input wire logic        cfg_write,
   input wire logic        ready_for_trigger,
   input wire logic        ext_trig1,
   input wire logic [1:0]  ext_trigx,
   input wire logic [15:0] operation_condition_register,
   input wire logic        aux_ready_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // six steady samples cover the synchroniser lag
   sequence s_pin_still;
      (!trigx_oe[0] && $stable(trigx_in[0])) [*6];
   endsequence
   sequence s_t1_still;
      $stable(trig1_in) [*6];
   endsequence
   a_oe_from_dir: assert property (
      cfg_write |-> ##2 trigx_oe == $past(cfg_dir_out, 2))
      else $error("enable not per direction");
   a_oe_only_write: assert property (
      $changed(trigx_oe) |-> $past(cfg_write, 2))
      else $error("enable moved without write");
   a_input_quiet: assert property (
      (trigx_out & ~trigx_oe) == 2'h0) else $error("input pin driven");
   a_reset_quiet: assert property (disable iff (1'b0)
      !rstn |=> trigx_oe == 2'h0 && aux_ready_n) else $error("reset state");
   a_pin_passed: assert property (
      s_pin_still |-> ext_trigx[0] == trigx_in[0]) else $error("pin lost");
   a_trig1_passed: assert property (
      s_t1_still |-> ext_trig1 == trig1_in) else $error("trigger one lost");
   a_ready_bit: assert property ($past(rstn) |->
      operation_condition_register == {10'h0, $past(ready_for_trigger), 5'h0})
      else $error("ready bit wrong");
   a_aux_low: assert property (
      aux_ready_n == !operation_condition_register[5]) else $error("aux ready");
endmodule : tiopg_chk

bind tiopg_top tiopg_chk tiopg_chk_i (.clk, .rstn, .trig1_in, .trigx_in,
   .trigx_out, .trigx_oe, .cfg_dir_out, .cfg_write, .ready_for_trigger,
   .ext_trig1, .ext_trigx, .operation_condition_register, .aux_ready_n);

// [bench/tiopg_top_tb.sv]
`timescale 1ns/1ps
module tiopg_top_tb;
   logic        clk = 0, rstn = 0, trig1_in = 0, cfg_write = 0;
   logic        acq_trigger = 0, ready_for_trigger = 0, ext_trig1, aux_ready_n;
   logic [1:0]  trigx_in, trigx_out, trigx_oe, ext_trigx;
   logic [1:0]  dir = 0, idle = 0, fire = 0, lvl = 0;
   logic [3:0]  src = 0;
   logic [47:0] wid = 0;
   logic [15:0] opc;
   int          err_total = 0, samples_checked = 0, n;
   always #2.5 clk = ~clk;
   tiopg_top tiopg_top_i (.clk, .rstn, .trig1_in, .trigx_in, .trigx_out,
      .trigx_oe, .cfg_dir_out(dir), .cfg_src(src), .cfg_idle_level(idle),
      .cfg_width(wid), .cfg_write, .fire, .acq_trigger, .ready_for_trigger,
      .ext_trig1, .ext_trigx, .operation_condition_register(opc),
      .aux_ready_n);
   tiopg_ext tiopg_ext_i (.oe(trigx_oe), .out(trigx_out), .lvl, .pin(trigx_in));
   task chk_v(input logic [19:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk_v
   task chk_n(input int got, exp);
      samples_checked++;
      if (got != exp) begin
         err_total++;
         $display("ERROR %0t length %0d expected %0d", $time, got, exp);
      end
   endtask : chk_n
   task stop_test;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   task tick(input int k);
      repeat (k) @(negedge clk);
   endtask : tick
   // config lands one edge after the write; extra cycles let out settle
   task cfg(input logic [1:0] d, input logic [3:0] s, input logic [1:0] i,
            input logic [23:0] w);
      dir = d; src = s; idle = i; wid = {w, w}; cfg_write = 1;
      tick(1);
      cfg_write = 0;
      tick(4);
   endtask : cfg
   task run(input logic l, output int k);
      k = 0;
      while (trigx_out[0] === l && k < 99) begin
         k++;
         tick(1);
      end
   endtask : run
   initial begin
      tick(20);
      rstn = 1;
      tick(1);
      chk_v({trigx_oe, aux_ready_n, opc}, 20'h1_0000);
      lvl = 2'h1; trig1_in = 1;
      tick(8);
      chk_v({ext_trig1, ext_trigx}, 20'h0_0005);
      cfg(2'h3, 4'h8, 2'h0, 24'h3); // codes 0 and 2 both on acquisition
      chk_v(trigx_oe, 20'h0_0003);
      acq_trigger = 1;
      tick(1);
      acq_trigger = 0;
      chk_v(trigx_out, 20'h0_0003);
      run(1, n);
      chk_n(n, 3);
      cfg(2'h1, 4'h1, 2'h0, 24'h3);
      ready_for_trigger = 1;
      tick(3);
      chk_v({trigx_out[0], aux_ready_n, opc}, 20'h2_0020);
      ready_for_trigger = 0;
      tick(3);
      chk_v({trigx_out[0], aux_ready_n, opc}, 20'h1_0000);
      cfg(2'h3, 4'hf, 2'h1, 24'h5);
      chk_v(trigx_out, 20'h0_0001);
      acq_trigger = 1;
      tick(1);
      acq_trigger = 0;
      tick(3);
      chk_v(trigx_out, 20'h0_0001);
      fire = 2'h3;
      tick(1);
      fire = 0;
      chk_v(trigx_out, 20'h0_0002);
      // the length is counted from the first cycle of the pulse
      fork
         run(0, n);
         begin
            tick(1);
            fire = 2'h1; // lands mid-pulse, must not stretch it
            tick(1);
            fire = 0;
         end
      join
      chk_n(n, 5);
      cfg(2'h0, 4'h0, 2'h0, 24'h0);
      chk_v({trigx_oe, trigx_out}, 20'h0_0000);
      stop_test;
   end
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      stop_test;
   end
endmodule : tiopg_top_tb
